/* tsr_top.sv */
// Temperature sensor serial readout: four-wire slave port, shutdown control and conversion sequencing.
// Assumes the serial pins are asynchronous to i_clk_sys and that the serial clock is
// slower than a quarter of the system clock; the front end delivers a steady 14-bit code.
//
// Overview of operation
// - Timer starts a conversion every second.
// - Conversion takes 800 us, then analog powers down.
// - Serial logic always on; latest result available.
// - Shutdown stops oscillator and further conversions.
// - All-zero control word leaves shutdown.
// - Leaving shutdown restarts oscillator, converts immediately.
// - Shutdown still returns last completed result.
// - Each serial access outside shutdown restarts timer and conversion.
// - Read during conversion aborts it; restart afterwards.
// - Result is 14-bit two's complement, sign top.
// - Positive code is temperature times 32.
// - Negative code minus 16384, over 32.
// - Active only with select low; else three-state.
// - Frame: 16 clocks, two zeros, 14 data.
// - Select held low repeats the same frame.
// - Data out changes on falling clock edge.
// - Data in sampled on rising clock edge.
// - Control write shares each read frame.
// - Third received bit is the power-down control.
// - Control word loads on 16th rising edge.
// - Early select rise discards partial control word.
// - Bits shift out most significant first.
`default_nettype none
`include "tsr_consts.svh"

module tsr_top
   import tsr_pkg::*;
#(
   parameter tsr_cnt_t P_PERIOD_CYCLES = tsr_cnt_t'(`TSR_PERIOD_CYCLES),
   parameter tsr_cnt_t P_CONV_CYCLES = tsr_cnt_t'(`TSR_CONV_CYCLES)
) (
   input wire logic i_clk_sys,              // System clock, 250 MHz.
   input wire logic i_rst,                  // Synchronous reset, active high.
   input wire logic i_cs_n,                 // Chip select pin, active low.
   input wire logic i_sclk,                 // Serial clock pin.
   input wire logic i_din,                  // Serial data input pin.
   input wire tsr_result_t i_sensor_code,   // Code from the analog front end.
   output logic o_dout,                     // Serial data output value.
   output logic o_dout_oe,                  // Output enable of the data pin, high while driving.
   output logic o_shutdown,                 // Shutdown mode is active.
   output logic o_analog_on,                // Analog section powered for a conversion.
   output tsr_result_t o_result             // Held temperature result.
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Bit of the outgoing word for a frame position; position 0 is the first bit out.
   function automatic logic tsr_frame_bit(input tsr_word_t word, input tsr_idx_t pos);
      tsr_idx_t sel;
      sel = `TSR_FRAME_LAST - pos;
      return word[sel];
   endfunction

   // Outgoing frame: two leading zeros above the result.
   function automatic tsr_word_t tsr_frame_word(input tsr_result_t res);
      return {`TSR_LEAD_ZEROS, res};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the first stage is read only by the second.

   tsr_pins_t pins_in;
   tsr_pins_t pins_meta_reg;
   tsr_pins_t pins_sync_reg;
   tsr_pins_t pins_prev_reg;

   assign pins_in = '{cs_n: i_cs_n, sclk: i_sclk, din: i_din};

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pins_meta_reg <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
         pins_sync_reg <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
         pins_prev_reg <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
      end else begin
         pins_meta_reg <= pins_in;
         pins_sync_reg <= pins_meta_reg;
         pins_prev_reg <= pins_sync_reg;
      end
   end

   logic selected;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;

   // Clock edges count only while selected; the select edge itself wins over a clock edge.
   assign selected = !pins_sync_reg.cs_n;
   assign cs_fall = !pins_sync_reg.cs_n && pins_prev_reg.cs_n;
   assign cs_rise = pins_sync_reg.cs_n && !pins_prev_reg.cs_n;
   assign sclk_rise = selected && !cs_fall && pins_sync_reg.sclk && !pins_prev_reg.sclk;
   assign sclk_fall = selected && !cs_fall && !pins_sync_reg.sclk && pins_prev_reg.sclk;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame position: counts rising edges and wraps every 16 clocks.

   tsr_idx_t bit_idx_reg;
   logic frame_end;

   assign frame_end = sclk_rise && (bit_idx_reg == `TSR_FRAME_LAST);

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         bit_idx_reg <= '0;
      end else if (!selected) begin
         bit_idx_reg <= '0;
      end else if (sclk_rise) begin
         bit_idx_reg <= bit_idx_reg + tsr_idx_t'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outgoing word, captured at frame start and again at each wrap so a frame is consistent.

   tsr_result_t result;
   tsr_word_t tx_word_reg;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         tx_word_reg <= '0;
      end else if (cs_fall || frame_end) begin
         tx_word_reg <= tsr_frame_word(result);
      end
   end

   // The first bit is out as soon as select falls; later bits follow falling clock edges.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_dout <= 1'b0;
      end else if (cs_fall) begin
         o_dout <= tsr_frame_bit(tsr_frame_word(result), '0);
      end else if (sclk_fall) begin
         o_dout <= tsr_frame_bit(tx_word_reg, bit_idx_reg);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_dout_oe <= 1'b0;
      end else begin
         o_dout_oe <= selected;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control word receiver; a partial word is never loaded.

   tsr_word_t rx_shift_reg;
   tsr_word_t rx_word;
   tsr_word_t power_control_word_reg;
   logic shutdown;

   assign rx_word = {rx_shift_reg[`TSR_CTRL_W-2:0], pins_sync_reg.din};

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rx_shift_reg <= `TSR_CTRL_RESET;
      end else if (!selected) begin
         rx_shift_reg <= `TSR_CTRL_RESET;
      end else if (sclk_rise) begin
         rx_shift_reg <= rx_word;
      end
   end

   // Other bits of the word are the host's to keep at zero; only the power-down bit acts.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         power_control_word_reg <= `TSR_CTRL_RESET;
      end else if (frame_end) begin
         power_control_word_reg <= rx_word;
      end
   end

   // Shutdown is the stored power-down bit itself, so it moves only with a complete word.
   assign shutdown = power_control_word_reg[`TSR_CTRL_PD_POS];

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer requests; registered so that shutdown is settled when they arrive.

   logic start_reg;
   logic abort_reg;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         start_reg <= 1'b0;
      end else begin
         start_reg <= (cs_rise && !shutdown) ||
                      (frame_end && shutdown && !rx_word[`TSR_CTRL_PD_POS]);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         abort_reg <= 1'b0;
      end else begin
         abort_reg <= cs_fall;
      end
   end

   tsr_conv_seq #(
      .P_PERIOD_CYCLES(P_PERIOD_CYCLES),
      .P_CONV_CYCLES(P_CONV_CYCLES)
   ) u_conv_seq (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_run(!shutdown),
      .i_start(start_reg),
      .i_abort(abort_reg),
      .i_sensor_code(i_sensor_code),
      .o_result(result),
      .o_busy(o_analog_on),
      .o_done()
   );

   assign o_shutdown = shutdown;
   assign o_result = result;

endmodule

`default_nettype wire

/* tsr_consts.svh */
// Constants of the temperature sensor serial readout: frame layout, reset values and timing counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH

// System clock rate.
`define TSR_CLK_HZ 250000000

// Automatic conversion interval in milliseconds, and its cycle count.
`define TSR_PERIOD_MS 1000
`define TSR_PERIOD_CYCLES ((`TSR_CLK_HZ / 1000) * `TSR_PERIOD_MS)

// Conversion time in microseconds, and its cycle count.
`define TSR_CONV_US 800
`define TSR_CONV_CYCLES ((`TSR_CLK_HZ / 1000000) * `TSR_CONV_US)

// Width of the conversion and interval counters.
`define TSR_CNT_W 28

// Result layout: 14 bits, sign on top.
`define TSR_RESULT_W 14
`define TSR_RESULT_SIGN_POS 13
`define TSR_RESULT_RESET 14'h0000

// Frame layout: 16 clocks, two leading zero bits, result below.
`define TSR_FRAME_BITS 16
`define TSR_FRAME_IDX_W 4
`define TSR_FRAME_LAST 4'hf
`define TSR_LEAD_ZEROS 2'h0

// Control word: the third received bit lands at position 13 after 16 shifts.
`define TSR_CTRL_W 16
`define TSR_CTRL_PD_POS 13
`define TSR_CTRL_RESET 16'h0000

`endif

/* tsr_pkg.sv */
// Types shared by the temperature sensor serial readout modules.
// Assumes tsr_consts.svh is on the include path.
`default_nettype none

package tsr_pkg;
`include "tsr_consts.svh"

   typedef logic [`TSR_CNT_W-1:0] tsr_cnt_t;
   typedef logic [`TSR_RESULT_W-1:0] tsr_result_t;
   typedef logic [`TSR_CTRL_W-1:0] tsr_word_t;
   typedef logic [`TSR_FRAME_IDX_W-1:0] tsr_idx_t;

   // The three serial input pins travel together through the synchroniser.
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } tsr_pins_t;

   typedef enum logic [0:0] {
      TSR_IDLE,
      TSR_CONV
   } tsr_conv_state_t;

endpackage

`default_nettype wire

/* tsr_conv_seq.sv */
// Conversion sequencer: interval timer, conversion timing and the held result.
// Assumes start and abort are one-cycle pulses on i_clk_sys that never coincide.
`default_nettype none
`include "tsr_consts.svh"

module tsr_conv_seq
   import tsr_pkg::*;
#(
   parameter tsr_cnt_t P_PERIOD_CYCLES = tsr_cnt_t'(`TSR_PERIOD_CYCLES),
   parameter tsr_cnt_t P_CONV_CYCLES = tsr_cnt_t'(`TSR_CONV_CYCLES)
) (
   input wire logic i_clk_sys,              // System clock.
   input wire logic i_rst,                  // Synchronous reset, active high.
   input wire logic i_run,                  // High in normal mode; low stops the oscillator.
   input wire logic i_start,                // Pulse: restart the timer and begin a conversion.
   input wire logic i_abort,                // Pulse: drop the conversion in progress.
   input wire tsr_result_t i_sensor_code,   // Code from the analog front end.
   output tsr_result_t o_result,            // Last completed result.
   output logic o_busy,                     // Conversion in progress, analog section powered.
   output logic o_done                      // Pulse when a result is stored.
);

   tsr_conv_state_t state_reg;
   tsr_cnt_t timer_reg;
   tsr_cnt_t conv_cnt_reg;
   tsr_result_t result_reg;
   logic tick;
   logic done;

   assign tick = i_run && (timer_reg == P_PERIOD_CYCLES - tsr_cnt_t'(1));
   assign done = (state_reg == TSR_CONV) && !i_start && !i_abort && i_run &&
                 (conv_cnt_reg == P_CONV_CYCLES - tsr_cnt_t'(1));

   ////////////////////////////////////////////////////////////////////////////////
   // Interval timer; held at zero while the oscillator is stopped.

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         timer_reg <= '0;
      end else if (!i_run || i_start) begin
         timer_reg <= '0;
      end else if (tick) begin
         timer_reg <= '0;
      end else begin
         timer_reg <= timer_reg + tsr_cnt_t'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Conversion state; a conversion also starts out of reset.

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_reg <= TSR_CONV;
      end else begin
         case (state_reg)
            TSR_IDLE: begin
               if (i_run && (i_start || tick)) begin
                  state_reg <= TSR_CONV;
               end
            end
            TSR_CONV: begin
               if (!i_run || i_abort) begin
                  state_reg <= TSR_IDLE;
               end else if (done) begin
                  state_reg <= TSR_IDLE;
               end
            end
            default: begin
               state_reg <= TSR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         conv_cnt_reg <= '0;
      end else if (state_reg != TSR_CONV || i_start) begin
         conv_cnt_reg <= '0;
      end else begin
         conv_cnt_reg <= conv_cnt_reg + tsr_cnt_t'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The result changes only on completion, so an aborted conversion leaves the old one.

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         result_reg <= `TSR_RESULT_RESET;
      end else if (done) begin
         result_reg <= i_sensor_code;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_done <= 1'b0;
      end else begin
         o_done <= done;
      end
   end

   assign o_result = result_reg;
   assign o_busy = (state_reg == TSR_CONV);

endmodule

`default_nettype wire

/* tsr_top_properties.sv */
// Port-level checker for the temperature sensor serial readout top.
// Assumes serial pins far slower than i_clk_sys and bound through the bind below.
`default_nettype none

module tsr_top_properties
   import tsr_pkg::*;
#(
   parameter tsr_cnt_t P_PERIOD_CYCLES = tsr_cnt_t'(2000),
   parameter tsr_cnt_t P_CONV_CYCLES = tsr_cnt_t'(200)
) (
   input wire logic i_clk_sys, // System clock.
   input wire logic i_rst, // Synchronous reset.
   input wire logic i_cs_n, // Chip select pin.
   input wire logic i_sclk, // Serial clock pin.
   input wire logic i_din, // Serial data in pin.
   input wire tsr_result_t i_sensor_code, // Front end code.
   input wire logic o_dout, // Data out value.
   input wire logic o_dout_oe, // Data out enable.
   input wire logic o_shutdown, // Shutdown mode.
   input wire logic o_analog_on, // Conversion running.
   input wire tsr_result_t o_result // Held result.
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   int conv_cnt;
   int per_cnt;
   logic on_q;
   logic [2:0] cs_hist;
   // Select as the sequencer sees it, three clocks late: an access restarts a running
   // conversion and the timer without a new rise of the analog enable.
   always_ff @(posedge i_clk_sys) begin
      cs_hist <= {cs_hist[1:0], i_cs_n};
   end
   // Cycles spent converting, and cycles since the last conversion start or access.
   always_ff @(posedge i_clk_sys) begin
      conv_cnt <= (i_rst || !o_analog_on || !cs_hist[2]) ? 0 : conv_cnt + 1;
   end
   always_ff @(posedge i_clk_sys) begin
      on_q <= o_analog_on;
      per_cnt <= (i_rst || (o_analog_on && !on_q) || o_shutdown || !cs_hist[2]) ? 0 : per_cnt + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_oe_off; i_cs_n [*5] |-> !o_dout_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("data out driven while deselected");
   property p_oe_on; !i_cs_n [*5] |-> o_dout_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("data out not driven while selected");
   property p_dout_fall; $changed(o_dout) && o_dout_oe && $past(o_dout_oe) |-> !i_sclk; endproperty
   a_dout_fall: assert property (p_dout_fall) else $error("data out moved with serial clock high");
   property p_result_cause;
      $changed(o_result) |-> $fell(o_analog_on) && ($past(conv_cnt) + 3 >= P_CONV_CYCLES);
   endproperty
   a_result_cause: assert property (p_result_cause) else $error("result changed without a full conversion");
   property p_conv_bound; conv_cnt <= P_CONV_CYCLES + 2; endproperty
   a_conv_bound: assert property (p_conv_bound) else $error("conversion ran too long");
   property p_period; per_cnt <= P_PERIOD_CYCLES + 2; endproperty
   a_period: assert property (p_period) else $error("no conversion within the interval");
   property p_sd_hold; o_shutdown && $past(o_shutdown) |-> !o_analog_on; endproperty
   a_sd_hold: assert property (p_sd_hold) else $error("conversion running in shutdown");
   property p_exit_conv; $fell(o_shutdown) |-> ##[0:2] o_analog_on; endproperty
   a_exit_conv: assert property (p_exit_conv) else $error("no conversion on leaving shutdown");
   property p_restart; $rose(i_cs_n) && !o_shutdown |-> ##[1:8] o_analog_on; endproperty
   a_restart: assert property (p_restart) else $error("no conversion after an access");
   property p_abort; $fell(i_cs_n) |-> ##[1:8] !o_analog_on; endproperty
   a_abort: assert property (p_abort) else $error("conversion not stopped by a read");
   property p_sd_frame; $changed(o_shutdown) |-> o_dout_oe && !i_cs_n; endproperty
   a_sd_frame: assert property (p_sd_frame) else $error("shutdown changed outside a frame");
   c_shutdown: cover property ($rose(o_shutdown));
   c_result: cover property ($changed(o_result));
   c_abort: cover property ($fell(i_cs_n) && o_analog_on);
endmodule

bind tsr_top tsr_top_properties #(
   .P_PERIOD_CYCLES(P_PERIOD_CYCLES),
   .P_CONV_CYCLES(P_CONV_CYCLES)
) u_props (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_din(i_din),
   .i_sensor_code(i_sensor_code), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_shutdown(o_shutdown),
   .o_analog_on(o_analog_on), .o_result(o_result)
);

`default_nettype wire

/* tsr_master_model.sv */
// Serial master model: frames of chip select, serial clock and data in.
// Assumes i_clk_sys at 4 ns, so ten cycles make each serial clock half of 40 ns.
`default_nettype none

module tsr_master_model (
   input wire logic i_clk_sys, // Pacing clock.
   input wire logic i_dout, // Device data out value.
   input wire logic i_dout_oe, // Device data out enable.
   output logic o_cs_n, // Chip select, active low.
   output logic o_sclk, // Serial clock, idles high.
   output logic o_din // Serial data to the device.
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released output floats, so a missing bit can never match.
   wire logic dout_line = i_dout_oe ? i_dout : 1'bz;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b1;
      o_din = 1'b0;
   end
   // Shifts n bits, word w repeated every 16, and returns what came back in rd.
   task automatic xfer(input logic [15:0] w, input int n, output logic [31:0] rd);
      rd = '0;
      @(negedge i_clk_sys) o_cs_n <= 1'b0;
      repeat (10) @(negedge i_clk_sys);
      for (int i = 0; i < n; i++) begin
         o_sclk <= 1'b0;
         o_din <= w[15 - (i % 16)];
         repeat (10) @(negedge i_clk_sys);
         rd = {rd[30:0], dout_line};
         o_sclk <= 1'b1;
         repeat (10) @(negedge i_clk_sys);
      end
      o_cs_n <= 1'b1;
      o_din <= ~o_din;
      repeat (2) @(negedge i_clk_sys);
   endtask
endmodule

`default_nettype wire

/* test_temp_sensor_serial_readout.sv */
// Testbench of the temperature sensor serial readout through its serial port.
// Assumes the master model drives the pins; intervals are shortened by parameters.
`default_nettype none

`define CHK(got, exp) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp); \
   end \
end

module test_temp_sensor_serial_readout
   import tsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   tsr_result_t code = 14'h0320;
   wire logic cs_n;
   wire logic sclk;
   wire logic din;
   wire logic dout;
   wire logic dout_oe;
   wire logic shutdown;
   wire logic analog_on;
   wire tsr_result_t result;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] rd;

   initial begin
      forever #2 i_clk_sys = ~i_clk_sys;
   end

   tsr_top #(.P_PERIOD_CYCLES(tsr_cnt_t'(2000)), .P_CONV_CYCLES(tsr_cnt_t'(200))) dut (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
      .i_sensor_code(code), .o_dout(dout), .o_dout_oe(dout_oe), .o_shutdown(shutdown),
      .o_analog_on(analog_on), .o_result(result)
   );
   tsr_master_model m (
      .i_clk_sys(i_clk_sys), .i_dout(dout), .i_dout_oe(dout_oe), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (n_mismatch == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task automatic set_code(input tsr_result_t c);
      @(negedge i_clk_sys) code <= c;
   endtask
   task automatic rd16(input logic [15:0] w, input tsr_result_t exp);
      m.xfer(w, 16, rd);
      `CHK(rd[15:0], {2'b00, exp})
   endtask

   // The whole run needs about 8700 cycles.
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(negedge i_clk_sys);
      i_rst <= 1'b0;
      idle(250);
      rd16(16'h0000, 14'h0320);
      set_code(14'h3ce0);
      idle(250);
      m.xfer(16'h0000, 32, rd);
      `CHK(rd, {2'b00, 14'h3ce0, 2'b00, 14'h3ce0})
      set_code(14'h0001);
      idle(20);
      rd16(16'h0000, 14'h3ce0);
      `CHK(result, 14'h3ce0)
      idle(250);
      rd16(16'h0000, 14'h0001);
      rd16(16'h2000, 14'h0001);
      `CHK(shutdown, 1'b1)
      set_code(14'h3b00);
      idle(2500);
      `CHK({shutdown, analog_on, result}, {2'b10, 14'h0001})
      rd16(16'h2000, 14'h0001);
      m.xfer(16'h0000, 8, rd);
      `CHK({shutdown, rd[7:0]}, {1'b1, 8'h00})
      rd16(16'h0000, 14'h0001);
      `CHK(shutdown, 1'b0)
      idle(2);
      `CHK(analog_on, 1'b1)
      idle(250);
      `CHK(result, 14'h3b00)
      set_code(14'h1f40);
      idle(1500);
      `CHK(result, 14'h3b00)
      idle(800);
      `CHK(result, 14'h1f40)
      end_of_test();
   end
endmodule

`default_nettype wire
